// ### verilog/fael_defines.svh
`ifndef FAEL_DEFINES_SVH
`define FAEL_DEFINES_SVH

// ----------------------------------------
// Timing, base periods in milliseconds; derived values in ticks or clock cycles
// ----------------------------------------
`define FAEL_CLK_KHZ         40000
`define FAEL_TICK_MS         50
`define FAEL_FAST_PERIOD_MS  200
`define FAEL_BLINK_PERIOD_MS 500
`define FAEL_SLOW_PERIOD_MS  3000
`define FAEL_SLOW_ON_MS      1000
`define FAEL_TICK_CYC   (`FAEL_TICK_MS * `FAEL_CLK_KHZ)
`define FAEL_FAST_HALF  (`FAEL_FAST_PERIOD_MS / 2 / `FAEL_TICK_MS)
`define FAEL_BLINK_HALF (`FAEL_BLINK_PERIOD_MS / 2 / `FAEL_TICK_MS)
`define FAEL_SLOW_TICKS (`FAEL_SLOW_PERIOD_MS / `FAEL_TICK_MS)
`define FAEL_SLOW_ON    (`FAEL_SLOW_ON_MS / `FAEL_TICK_MS)
`define FAEL_BOOT_CYC   8

// ----------------------------------------
// Error codes
// ----------------------------------------
`define FAEL_CODE_SUPPLY  16'h002A
`define FAEL_CODE_RLOST   16'h1500
`define FAEL_CODE_REMOTE  16'h1500
`define FAEL_CODE_EXT     16'h1800
`define FAEL_CODE_HB      16'h1900
`define FAEL_HB_MAX_ID    8'h1C
`define FAEL_REMOTE_MIN   4'h2
`define FAEL_CODE_BATT    16'h0027
`define FAEL_CODE_RTC     16'h0026
`define FAEL_CODE_ID      16'h0011
`define FAEL_CODE_PW      16'h0012
`define FAEL_CODE_PWX     16'h002D
`define FAEL_CODE_RET0    16'h0050
`define FAEL_CODE_RET1    16'h0051
`define FAEL_CODE_RET2    16'h0052
`define FAEL_CODE_RET3    16'h0054
`define FAEL_CODE_RET4    16'h0055
`define FAEL_CODE_RET5    16'h0056
`define FAEL_CODE_RET6    16'h0059
`define FAEL_CODE_CARD    16'h005D

// ----------------------------------------
// Flag positions
// ----------------------------------------
`define FAEL_NFLAG     9
`define FAEL_F_SUPPLY  0
`define FAEL_F_REMOTE  1
`define FAEL_F_EXT     2
`define FAEL_F_BATT    3
`define FAEL_F_CLOCK   4
`define FAEL_F_ACCESS  5
`define FAEL_F_RETAIN  6
`define FAEL_F_CARD    7
`define FAEL_F_HB      8

// ----------------------------------------
// Event positions, lowest served first
// ----------------------------------------
`define FAEL_NEV     12
`define FAEL_E_SUP   0
`define FAEL_E_RLOST 1
`define FAEL_E_RERR  2
`define FAEL_E_EXT   3
`define FAEL_E_HB    4
`define FAEL_E_BATT  5
`define FAEL_E_RTC   6
`define FAEL_E_ID    7
`define FAEL_E_PW    8
`define FAEL_E_PWX   9
`define FAEL_E_RET   10
`define FAEL_E_CARD  11

`endif

// ### verilog/fael_pkg.sv
package fael_pkg;
	typedef enum logic [4:0] {
		FAEL_M_IDLE = 5'h01,
		FAEL_M_FAST = 5'h02,
		FAEL_M_SLOW = 5'h04,
		FAEL_M_UPG  = 5'h08,
		FAEL_M_CARD = 5'h10
	} fael_mode_t;
endpackage

// ### verilog/fael_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Three-stage input filter
// ----------------------------------------
// A change is taken once the second and third stages agree.
module fael_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= (s2 & s3) | (q & (s2 | s3));
		end
	end
endmodule

`default_nettype wire

// ### verilog/fael_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fael_defines.svh"

module fael_top
	import fael_pkg::*;
#(
	parameter int TICK_CYC = `FAEL_TICK_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   supply_bad,
	input  wire logic                   remote_lost,
	input  wire logic                   remote_err,
	input  wire logic [3:0]             remote_sub,
	input  wire logic                   ext_err,
	input  wire logic [3:0]             ext_sub,
	input  wire logic                   hb_err,
	input  wire logic [7:0]             hb_slave,
	input  wire logic                   battery_low,
	input  wire logic                   rtc_fail,
	input  wire logic                   fw_upgrade,
	input  wire logic                   card_busy,
	input  wire logic                   id_wrong,
	input  wire logic                   pw_wrong,
	input  wire logic                   pw_exceeded,
	input  wire logic                   retain_err,
	input  wire logic [2:0]             retain_sel,
	input  wire logic                   card_missing,
	input  wire logic                   boot_fail,
	input  wire logic                   cpu_run,
	input  wire logic [`FAEL_NFLAG-1:0] flag_clear,
	input  wire logic                   batt_report_on,
	input  wire logic                   batt_report_off,
	input  wire logic                   factory_restore,
	output logic                        run_led,
	output logic                        error_led,
	output logic                        battery_low_indicator,
	output logic [15:0]                 error_code,
	output logic                        code_strobe,
	output logic                        log_strobe,
	output logic                        supply_fault_flag,
	output logic                        remote_module_fault_flag,
	output logic                        extension_module_fault_flag,
	output logic                        battery_low_flag,
	output logic                        clock_fault_flag,
	output logic                        access_fault_flag,
	output logic                        retained_memory_fault_flag,
	output logic                        memory_card_fault_flag,
	output logic                        access_lockout,
	output logic                        upgrade_failed,
	output logic                        batt_report_en
);
	localparam int TW = $clog2(TICK_CYC);

	// ----------------------------------------
	// Input filtering
	// ----------------------------------------
	logic        s_sup;
	logic        s_rlost;
	logic        s_rerr;
	logic [3:0]  s_rsub;
	logic        s_ext;
	logic [3:0]  s_esub;
	logic        s_hb;
	logic [7:0]  s_slave;
	logic        s_batt;
	logic        s_rtc;
	logic        s_upg;
	logic        s_cbusy;
	logic        s_id;
	logic        s_pw;
	logic        s_pwx;
	logic        s_ret;
	logic [2:0]  s_rsel;
	logic        s_cmiss;
	logic        s_boot;
	logic        s_run;
	logic [34:0] s_bus;

	fael_sync #(.W(35)) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({supply_bad, remote_lost, remote_err, remote_sub, ext_err,
		         ext_sub, hb_err, hb_slave, battery_low, rtc_fail, fw_upgrade,
		         card_busy, id_wrong, pw_wrong, pw_exceeded, retain_err,
		         retain_sel, card_missing, boot_fail, cpu_run}),
		.q     (s_bus)
	);

	assign {s_sup, s_rlost, s_rerr, s_rsub, s_ext, s_esub, s_hb, s_slave,
	        s_batt, s_rtc, s_upg, s_cbusy, s_id, s_pw, s_pwx, s_ret,
	        s_rsel, s_cmiss, s_boot, s_run} = s_bus;

	// ----------------------------------------
	// Timebase
	// ----------------------------------------
	logic [TW-1:0] tick_cnt;
	logic [5:0]    phase;
	logic          tick;

	assign tick = tick_cnt == TW'(TICK_CYC - 1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= '0;
			phase    <= 6'h00;
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			if (tick) begin
				phase <= (phase == 6'(`FAEL_SLOW_TICKS - 1)) ? 6'h00 : phase + 6'h01;
			end
		end
	end

	// ----------------------------------------
	// Event capture and service
	// ----------------------------------------
	// Events raised together are queued so that none is lost;
	// the lowest position is reported first, one per cycle.
	logic [`FAEL_NEV-1:0] lvl;
	logic [`FAEL_NEV-1:0] lvl_q;
	logic [`FAEL_NEV-1:0] pend;
	logic [`FAEL_NEV-1:0] srv;
	logic [`FAEL_NFLAG-1:0] fset;
	logic [`FAEL_NFLAG-1:0] flags;
	logic [15:0] next_code;
	logic        next_ok;
	logic        next_log;
	logic        lock_set;

	always_comb begin
		lvl = '0;
		lvl[`FAEL_E_SUP]   = s_sup;
		lvl[`FAEL_E_RLOST] = s_rlost;
		lvl[`FAEL_E_RERR]  = s_rerr;
		lvl[`FAEL_E_EXT]   = s_ext;
		lvl[`FAEL_E_HB]    = s_hb;
		lvl[`FAEL_E_BATT]  = s_batt & batt_report_en;
		lvl[`FAEL_E_RTC]   = s_rtc;
		lvl[`FAEL_E_ID]    = s_id;
		lvl[`FAEL_E_PW]    = s_pw;
		lvl[`FAEL_E_PWX]   = s_pwx;
		lvl[`FAEL_E_RET]   = s_ret;
		lvl[`FAEL_E_CARD]  = s_cmiss;
	end

	assign srv = pend & (~pend + 1'b1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl_q <= '0;
			pend  <= '0;
		end else begin
			lvl_q <= lvl;
			pend  <= (pend & ~srv) | (lvl & ~lvl_q);
		end
	end

	function automatic logic [15:0] ret_code(input logic [2:0] sel);
		unique case (sel)
			3'h0: ret_code = `FAEL_CODE_RET0;
			3'h1: ret_code = `FAEL_CODE_RET1;
			3'h2: ret_code = `FAEL_CODE_RET2;
			3'h3: ret_code = `FAEL_CODE_RET3;
			3'h4: ret_code = `FAEL_CODE_RET4;
			3'h5: ret_code = `FAEL_CODE_RET5;
			default: ret_code = `FAEL_CODE_RET6;
		endcase
	endfunction

	always_comb begin
		next_code = 16'h0000;
		next_ok   = 1'b0;
		next_log  = 1'b0;
		fset      = '0;
		lock_set  = 1'b0;
		unique case (1'b1)
			srv[`FAEL_E_SUP]: begin
				next_code = `FAEL_CODE_SUPPLY;
				next_ok   = 1'b1;
				next_log  = 1'b1;
				fset[`FAEL_F_SUPPLY] = 1'b1;
			end
			srv[`FAEL_E_RLOST]: begin
				next_code = `FAEL_CODE_RLOST;
				next_ok   = 1'b1;
				next_log  = 1'b1;
				fset[`FAEL_F_REMOTE] = 1'b1;
			end
			srv[`FAEL_E_RERR]: begin
				next_code = `FAEL_CODE_REMOTE | {12'h000, s_rsub};
				next_ok   = s_rsub >= `FAEL_REMOTE_MIN;
				next_log  = next_ok;
				fset[`FAEL_F_REMOTE] = next_ok;
			end
			srv[`FAEL_E_EXT]: begin
				next_code = `FAEL_CODE_EXT | {12'h000, s_esub};
				next_ok   = 1'b1;
				next_log  = 1'b1;
				fset[`FAEL_F_EXT] = 1'b1;
			end
			srv[`FAEL_E_HB]: begin
				next_code = `FAEL_CODE_HB | {8'h00, s_slave};
				next_ok   = s_slave <= `FAEL_HB_MAX_ID;
				next_log  = next_ok;
				fset[`FAEL_F_HB] = next_ok;
			end
			srv[`FAEL_E_BATT]: begin
				next_code = `FAEL_CODE_BATT;
				next_ok   = 1'b1;
				fset[`FAEL_F_BATT] = 1'b1;
			end
			srv[`FAEL_E_RTC]: begin
				next_code = `FAEL_CODE_RTC;
				next_ok   = 1'b1;
				next_log  = 1'b1;
				fset[`FAEL_F_CLOCK] = 1'b1;
			end
			srv[`FAEL_E_ID], srv[`FAEL_E_PW]: begin
				next_code = srv[`FAEL_E_ID] ? `FAEL_CODE_ID : `FAEL_CODE_PW;
				next_ok   = 1'b1;
				next_log  = 1'b1;
				fset[`FAEL_F_ACCESS] = 1'b1;
			end
			srv[`FAEL_E_PWX]: begin
				next_code = `FAEL_CODE_PWX;
				next_ok   = 1'b1;
				next_log  = 1'b1;
				lock_set  = 1'b1;
				fset[`FAEL_F_ACCESS] = 1'b1;
			end
			srv[`FAEL_E_RET]: begin
				next_code = ret_code(s_rsel);
				next_ok   = s_rsel != 3'h7;
				next_log  = next_ok;
				fset[`FAEL_F_RETAIN] = next_ok;
			end
			srv[`FAEL_E_CARD]: begin
				next_code = `FAEL_CODE_CARD;
				next_ok   = 1'b1;
				next_log  = 1'b1;
				fset[`FAEL_F_CARD] = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			error_code  <= 16'h0000;
			code_strobe <= 1'b0;
			log_strobe  <= 1'b0;
		end else begin
			code_strobe <= next_ok;
			log_strobe  <= next_ok & next_log;
			if (next_ok) begin
				error_code <= next_code;
			end
		end
	end

	// ----------------------------------------
	// Sticky flags and lockout
	// ----------------------------------------
	// The access flag cannot be cleared while the lockout stands.
	logic [`FAEL_NFLAG-1:0] clr_eff;

	always_comb begin
		clr_eff = flag_clear;
		clr_eff[`FAEL_F_ACCESS] = flag_clear[`FAEL_F_ACCESS] & ~access_lockout;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr_eff) | fset;
		end
	end

	assign supply_fault_flag           = flags[`FAEL_F_SUPPLY];
	assign remote_module_fault_flag    = flags[`FAEL_F_REMOTE];
	assign extension_module_fault_flag = flags[`FAEL_F_EXT];
	assign battery_low_flag            = flags[`FAEL_F_BATT];
	assign clock_fault_flag            = flags[`FAEL_F_CLOCK];
	assign access_fault_flag           = flags[`FAEL_F_ACCESS];
	assign retained_memory_fault_flag  = flags[`FAEL_F_RETAIN];
	assign memory_card_fault_flag      = flags[`FAEL_F_CARD];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			access_lockout <= 1'b0;
		end else if (lock_set) begin
			access_lockout <= 1'b1;
		end else if (factory_restore) begin
			access_lockout <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			batt_report_en <= 1'b1;
		end else if (batt_report_off) begin
			batt_report_en <= 1'b0;
		end else if (batt_report_on) begin
			batt_report_en <= 1'b1;
		end
	end

	// ----------------------------------------
	// Power-up upgrade check
	// ----------------------------------------
	// Only a failure reported just after reset counts; later changes
	// of the strap are ignored until the next reset.
	logic [3:0] boot_cnt;
	logic       boot_open;

	assign boot_open = boot_cnt != 4'(`FAEL_BOOT_CYC);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_cnt       <= 4'h0;
			upgrade_failed <= 1'b0;
		end else begin
			if (boot_open) begin
				boot_cnt <= boot_cnt + 4'h1;
			end
			if (boot_open && s_boot) begin
				upgrade_failed <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Indicators
	// ----------------------------------------
	fael_mode_t led_mode;
	fael_mode_t next_mode;
	logic       fast_on;
	logic       blink_on;
	logic       slow_on;
	logic       next_run;
	logic       next_err;
	logic       next_bat;

	assign fast_on  = (phase % 6'(2 * `FAEL_FAST_HALF)) < 6'(`FAEL_FAST_HALF);
	assign blink_on = (phase % 6'(2 * `FAEL_BLINK_HALF)) < 6'(`FAEL_BLINK_HALF);
	assign slow_on  = phase < 6'(`FAEL_SLOW_ON);

	always_comb begin
		if (s_upg || upgrade_failed) begin
			next_mode = FAEL_M_UPG;
		end else if (s_cbusy) begin
			next_mode = FAEL_M_CARD;
		end else if (s_sup) begin
			next_mode = FAEL_M_FAST;
		end else if (flags[`FAEL_F_REMOTE] || flags[`FAEL_F_EXT] || flags[`FAEL_F_HB]) begin
			next_mode = FAEL_M_SLOW;
		end else begin
			next_mode = FAEL_M_IDLE;
		end
	end

	always_comb begin
		next_run = s_run;
		next_err = 1'b0;
		unique case (next_mode)
			FAEL_M_UPG: begin
				next_run = blink_on;
				next_err = blink_on;
			end
			FAEL_M_CARD: begin
				next_run = blink_on;
				next_err = ~blink_on;
			end
			FAEL_M_FAST: next_err = fast_on;
			FAEL_M_SLOW: next_err = slow_on;
			FAEL_M_IDLE: next_err = 1'b0;
		endcase
		if (s_rtc) begin
			next_bat = blink_on;
		end else begin
			next_bat = s_batt & batt_report_en;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			led_mode              <= FAEL_M_IDLE;
			run_led               <= 1'b0;
			error_led             <= 1'b0;
			battery_low_indicator <= 1'b0;
		end else begin
			led_mode              <= next_mode;
			run_led               <= next_run;
			error_led             <= next_err;
			battery_low_indicator <= next_bat;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	supply_code_a: assert property (
		code_strobe && error_code == `FAEL_CODE_SUPPLY |-> supply_fault_flag && log_strobe)
		else $error("supply code without flag or log");
	remote_code_a: assert property (
		code_strobe && error_code[15:8] == 8'h15
		|-> remote_module_fault_flag && log_strobe && error_code[7:0] != 8'h01)
		else $error("remote code wrong");
	ext_code_a: assert property (
		code_strobe && error_code[15:8] == 8'h18 |-> extension_module_fault_flag && log_strobe)
		else $error("extension code wrong");
	hb_code_a: assert property (
		code_strobe && error_code[15:8] == 8'h19
		|-> log_strobe && error_code[7:0] <= `FAEL_HB_MAX_ID)
		else $error("heartbeat code wrong");
	batt_nolog_a: assert property (
		code_strobe && error_code == `FAEL_CODE_BATT |-> !log_strobe && battery_low_flag)
		else $error("battery code logged or unflagged");
	lockout_hold_a: assert property (
		$past(access_lockout) && !$past(factory_restore) |-> access_lockout && access_fault_flag)
		else $error("lockout dropped");
	retain_code_a: assert property (
		code_strobe && error_code[15:4] == 12'h005 && error_code[3:0] <= 4'h9
		|-> retained_memory_fault_flag && log_strobe)
		else $error("retained code wrong");
	card_code_a: assert property (
		code_strobe && error_code == `FAEL_CODE_CARD |-> memory_card_fault_flag && log_strobe)
		else $error("card code wrong");
	slow_shape_a: assert property (
		led_mode == FAEL_M_SLOW |-> error_led == ($past(phase) < 6'h14))
		else $error("slow pattern wrong");
	fast_step_a: assert property (
		led_mode == FAEL_M_FAST && $past(led_mode) == FAEL_M_FAST && $changed(error_led)
		|-> $past(tick, 2))
		else $error("fast blink changed off tick");
	inphase_a: assert property (
		led_mode == FAEL_M_UPG |-> run_led == error_led)
		else $error("upgrade blink out of phase");
	alternate_a: assert property (
		led_mode == FAEL_M_CARD |-> run_led != error_led)
		else $error("card blink not alternate");
	sticky_flag_a: assert property (
		&(~$past(flags) | $past(flag_clear) | flags))
		else $error("flag dropped without clear");
	batt_default_a: assert property (
		$past(!rst_b) |-> batt_report_en)
		else $error("battery reporting not enabled after reset");
endmodule

`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic [11:0]       ev = 12'h000;
	logic [7:0]        sub = 8'h00;
	logic              fw_upg = 1'b0;
	logic              card_busy = 1'b0;
	logic              boot_fail = 1'b0;
	logic              batt_on = 1'b0;
	logic              batt_off = 1'b0;
	logic              restore = 1'b0;
	logic [8:0]        clr = 9'h000;
	wire logic         run_led, error_led, batt_ind, code_strobe, log_strobe;
	wire logic         lockout, upg_failed, rep_en;
	wire logic [15:0]  error_code;
	wire logic [7:0]   flags;
	int                n_fail = 0;
	int                n_checks = 0;
	int                nh [3];
	int                nr [3];
	int                nsame;
	bit                locked = 1'b0;
	localparam logic [15:0] RET [7] = '{16'h0050, 16'h0051, 16'h0052, 16'h0054,
		16'h0055, 16'h0056, 16'h0059};

	always #12.5 clk = ~clk;

	// Short timebase keeps a full phase cycle (slow pattern) at 240 clocks
	fael_top #(.TICK_CYC(4)) u_dut (
		.clk(clk), .rst_b(rst_b),
		.supply_bad(ev[0]), .remote_lost(ev[1]), .remote_err(ev[2]),
		.remote_sub(sub[3:0]), .ext_err(ev[3]), .ext_sub(sub[3:0]),
		.hb_err(ev[4]), .hb_slave(sub), .battery_low(ev[5]), .rtc_fail(ev[6]),
		.fw_upgrade(fw_upg), .card_busy(card_busy), .id_wrong(ev[7]),
		.pw_wrong(ev[8]), .pw_exceeded(ev[9]), .retain_err(ev[10]),
		.retain_sel(sub[2:0]), .card_missing(ev[11]), .boot_fail(boot_fail),
		.cpu_run(1'b0), .flag_clear(clr), .batt_report_on(batt_on),
		.batt_report_off(batt_off), .factory_restore(restore),
		.run_led(run_led), .error_led(error_led), .battery_low_indicator(batt_ind),
		.error_code(error_code), .code_strobe(code_strobe), .log_strobe(log_strobe),
		.supply_fault_flag(flags[0]), .remote_module_fault_flag(flags[1]),
		.extension_module_fault_flag(flags[2]), .battery_low_flag(flags[3]),
		.clock_fault_flag(flags[4]), .access_fault_flag(flags[5]),
		.retained_memory_fault_flag(flags[6]), .memory_card_fault_flag(flags[7]),
		.access_lockout(lockout), .upgrade_failed(upg_failed), .batt_report_en(rep_en)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic step(int n = 1);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic check(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Bounded wait; strobe lasts one cycle so every cycle is sampled
	task automatic wait_strobe(output bit got);
		got = 1'b0;
		for (int i = 0; i < 30 && !got; i++) begin
			step();
			got = (code_strobe === 1'b1);
		end
	endtask

	task automatic clear_all();
		clr = 9'h1FF;
		step();
		clr = 9'h000;
		step();
	endtask

	task automatic fire(int e, logic [7:0] s, logic [15:0] code, logic lg, logic [7:0] fl);
		bit got;
		sub = s;
		ev[e] = 1'b1;
		wait_strobe(got);
		if (!got) begin
			n_fail++;
			finish_test();
		end
		check(error_code, code);
		check({15'h0, log_strobe}, {15'h0, lg});
		check({8'h0, flags}, {8'h0, fl});
		ev[e] = 1'b0;
		step(8);
		check({8'h0, flags}, {8'h0, fl});
		clear_all();
		check({8'h0, flags}, locked ? 16'h0020 : 16'h0000);
	endtask

	task automatic none(int e, logic [7:0] s);
		bit got;
		sub = s;
		ev[e] = 1'b1;
		wait_strobe(got);
		check({15'h0, got}, 16'h0000);
		ev[e] = 1'b0;
		step(8);
	endtask

	// Counts over one whole phase cycle (slow pattern), so the start phase does not matter
	task automatic measure();
		logic [2:0] p, c;
		nh = '{0, 0, 0};
		nr = '{0, 0, 0};
		nsame = 0;
		step(10);
		p = {batt_ind, error_led, run_led};
		for (int i = 0; i < 240; i++) begin
			step();
			c = {batt_ind, error_led, run_led};
			for (int k = 0; k < 3; k++) begin
				nh[k] += int'(c[k]);
				nr[k] += int'(c[k] & !p[k]);
			end
			nsame += int'(c[0] === c[1]);
			p = c;
		end
	endtask

	task automatic led(int k, int hi, int rises);
		measure();
		check(16'(nh[k]), 16'(hi));
		check(16'(nr[k]), 16'(rises));
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	task automatic sc_codes();
		step(3);
		rst_b = 1'b1;
		check({8'h0, flags}, 16'h0000);
		check({13'h0, run_led, error_led, batt_ind}, 16'h0000);
		check({15'h0, rep_en}, 16'h0001);
		fire(0, 8'h00, 16'h002A, 1'b1, 8'h01);
		fire(1, 8'h00, 16'h1500, 1'b1, 8'h02);
		fire(2, 8'h02, 16'h1502, 1'b1, 8'h02);
		fire(2, 8'h0F, 16'h150F, 1'b1, 8'h02);
		none(2, 8'h01);
		fire(3, 8'h00, 16'h1800, 1'b1, 8'h04);
		fire(3, 8'h0F, 16'h180F, 1'b1, 8'h04);
		fire(4, 8'h1C, 16'h191C, 1'b1, 8'h00);
		none(4, 8'h1D);
		fire(5, 8'h00, 16'h0027, 1'b0, 8'h08);
		fire(6, 8'h00, 16'h0026, 1'b1, 8'h10);
		fire(7, 8'h00, 16'h0011, 1'b1, 8'h20);
		fire(8, 8'h00, 16'h0012, 1'b1, 8'h20);
		for (int i = 0; i < 7; i++) begin
			fire(10, 8'(i), RET[i], 1'b1, 8'h40);
		end
		fire(11, 8'h00, 16'h005D, 1'b1, 8'h80);
	endtask

	task automatic sc_lockout();
		locked = 1'b1;
		fire(9, 8'h00, 16'h002D, 1'b1, 8'h20);
		check({15'h0, lockout}, 16'h0001);
		restore = 1'b1;
		step();
		restore = 1'b0;
		locked = 1'b0;
		clear_all();
		check({14'h0000, lockout, flags[5]}, 16'h0000);
	endtask

	// Indicator patterns
	task automatic sc_blink();
		ev[0] = 1'b1;
		led(1, 120, 15);
		ev[0] = 1'b0;
		ev[1] = 1'b1;
		step(10);
		ev[1] = 1'b0;
		led(1, 80, 1);
		clear_all();
	endtask

	task automatic sc_battery();
		ev[6] = 1'b1;
		led(2, 120, 6);
		ev[6] = 1'b0;
		ev[5] = 1'b1;
		led(2, 240, 0);
		ev[5] = 1'b0;
		clear_all();
		batt_off = 1'b1;
		step();
		batt_off = 1'b0;
		check({15'h0, rep_en}, 16'h0000);
		none(5, 8'h00);
		ev[5] = 1'b1;
		led(2, 0, 0);
		ev[5] = 1'b0;
		// Let the filtered level fall first, else re-enabling raises a battery event
		step(6);
		batt_on = 1'b1;
		step();
		batt_on = 1'b0;
		check({15'h0, rep_en}, 16'h0001);
	endtask

	task automatic sc_modes();
		fw_upg = 1'b1;
		led(0, 120, 6);
		check(16'(nsame), 16'h00F0);
		fw_upg = 1'b0;
		card_busy = 1'b1;
		led(1, 120, 6);
		check(16'(nsame), 16'h0000);
		card_busy = 1'b0;
	endtask

	// Second reset with a failed upgrade reported at power-up
	task automatic sc_boot();
		boot_fail = 1'b1;
		rst_b = 1'b0;
		step(3);
		rst_b = 1'b1;
		step(12);
		boot_fail = 1'b0;
		check({15'h0, upg_failed}, 16'h0001);
		led(0, 120, 6);
		check(16'(nsame), 16'h00F0);
	endtask

	initial begin
		sc_codes();
		sc_lockout();
		sc_blink();
		sc_battery();
		sc_modes();
		sc_boot();
		finish_test();
	end
endmodule

`default_nettype wire
